// file: pkg/fsrb_pkg.sv
// Constants, field layout and carrier types of the fault status register bank.
// Assumes an APB master with 32-bit data on the same clock as the bank.
//
// Summary of operation
// - Power-stage fault word at index E0h, read-only, reads zero after reset.
// - Power-stage bit 31 is the OR of every power-stage fault flag.
// - Power-stage bit 30 shows a regulator fault.
// - Power-stage bit 28 shows any overcurrent condition.
// - Power-stage bit 27 is low while a supply power-on reset is seen.
// - Power-stage bit 26 shows supply overvoltage.
// - Power-stage bit 25 shows thermal warning or thermal shutdown.
// - Power-stage bit 23 shows thermal warning.
// - Power-stage bit 22 shows thermal shutdown.
// - Bits 21 to 16 show overcurrent per switch, phase C high first.
// - Power-stage bit 14 shows a one-time-programmable memory error.
// - Power-stage bit 13 shows regulator overcurrent.
// - Power-stage bit 12 shows regulator undervoltage.
// - Power-stage bit 11 shows charge pump undervoltage.
// - Controller fault word at index E2h, read-only, reads zero after reset.
// - Controller bit 31 is the OR of every controller fault flag.
// - Controller bit 25 shows a resistance and inductance measurement error.
// - Controller bit 20 shows the rotor lock flag only; the two lock limit flags sit at bits 19 and 18.
// - Controller bit 17 shows load supply undervoltage.
package fsrb_pkg;

  // Register indices and byte addresses (one aligned word per index)
  localparam int APB_AW = 12;
  localparam logic [7:0] PWR_IDX = 8'he0;
  localparam logic [7:0] CTL_IDX = 8'he2;
  localparam logic [APB_AW-1:0] PWR_ADDR = {2'h0, PWR_IDX, 2'h0};
  localparam logic [APB_AW-1:0] CTL_ADDR = {2'h0, CTL_IDX, 2'h0};
  localparam logic [31:0] PWR_RESET = 32'h0000_0000;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;

  // Power-stage word field positions
  localparam int PWR_SUM_BIT = 31;
  localparam int PWR_REG_FAULT_BIT = 30;
  localparam int PWR_OC_ANY_BIT = 28;
  localparam int PWR_POR_N_BIT = 27;
  localparam int PWR_OV_BIT = 26;
  localparam int PWR_THERM_ANY_BIT = 25;
  localparam int PWR_THERM_WARN_BIT = 23;
  localparam int PWR_THERM_SHUT_BIT = 22;
  localparam int PWR_SWITCH_LSB = 16;
  localparam int PWR_OTP_BIT = 14;
  localparam int PWR_REG_OC_BIT = 13;
  localparam int PWR_REG_UV_BIT = 12;
  localparam int PWR_CP_UV_BIT = 11;

  // Controller word field positions: flags occupy 29..14, bit 30 reserved
  localparam int CTL_SUM_BIT = 31;
  localparam int CTL_FLAG_LSB = 14;
  localparam int CTL_FLAG_MSB = 29;
  localparam int CTL_RL_ERR_BIT = 25;
  localparam int CTL_LOCK_BIT = 20;
  localparam int CTL_UV_BIT = 17;

  // Synchroniser settle count before the active-low supply flag is trusted
  localparam logic [1:0] SYNC_SETTLE = 2'h2;

  // Power-stage detector levels
  typedef struct packed {
    logic regulator_fault_flag;
    logic overcurrent_any_flag;
    logic supply_reset_n_flag;
    logic supply_overvoltage_flag;
    logic thermal_warning_flag;
    logic thermal_shutdown_flag;
    logic phase_c_high_overcurrent;
    logic phase_c_low_overcurrent;
    logic phase_b_high_overcurrent;
    logic phase_b_low_overcurrent;
    logic phase_a_high_overcurrent;
    logic phase_a_low_overcurrent;
    logic otp_error_flag;
    logic regulator_overcurrent_flag;
    logic regulator_undervoltage_flag;
    logic charge_pump_low_flag;
  } fsrb_pwr_flags_s;

  // Controller detector levels, most significant field is bit 29
  typedef struct packed {
    logic pulse_freq_fault;
    logic pulse_t1_fault;
    logic pulse_t2_fault;
    logic bus_limit_flag;
    logic rl_measure_error;
    logic emf_measure_error;
    logic speed_abnormal_flag;
    logic emf_abnormal_flag;
    logic motor_absent_flag;
    logic rotor_lock_flag;
    logic lock_limit_flag;
    logic hw_lock_limit_flag;
    logic load_supply_low_flag;
    logic load_supply_high_flag;
    logic speed_loop_sat_flag;
    logic current_loop_sat_flag;
  } fsrb_ctl_flags_s;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata;
  } fsrb_apb_req_s;

  // APB answer to the master
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } fsrb_apb_rsp_s;

endpackage : fsrb_pkg

// file: rtl/fsrb_top.sv
// Read-only bank of the power-stage and controller fault status words.
// Assumes detector levels arrive asynchronously and an APB master on i_clk.
//
// The APB register port was decided locally.
`timescale 1ns/100ps
module fsrb_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // APB slave
  input wire fsrb_pkg::fsrb_apb_req_s i_apb,
  output fsrb_pkg::fsrb_apb_rsp_s o_apb,
  // Detector levels
  input wire fsrb_pkg::fsrb_pwr_flags_s i_pwr_flags,
  input wire fsrb_pkg::fsrb_ctl_flags_s i_ctl_flags,
  // Summary levels for fault pins
  output logic o_pwr_fault,
  output logic o_ctl_fault
);
  import fsrb_pkg::*;

  // All state of the bank
  typedef struct packed {
    fsrb_pwr_flags_s pwr_meta;
    fsrb_pwr_flags_s pwr_sync;
    fsrb_ctl_flags_s ctl_meta;
    fsrb_ctl_flags_s ctl_sync;
    logic [1:0] settle;
    logic [31:0] rdata;
    logic slverr;
  } fsrb_state_s;

  fsrb_state_s state_r;
  fsrb_state_s state_nxt;
  logic supply_valid;
  logic [31:0] pwr_word;
  logic [31:0] ctl_word;
  logic setup_phase;
  logic read_setup;
  logic write_setup;
  logic pwr_hit;
  logic ctl_hit;
  logic addr_known;
  logic refuse;
  logic [31:0] read_word;
  logic supply_reset_seen;
  logic [15:0] pwr_fault_vec;
  logic [15:0] ctl_fault_vec;
  logic pwr_any_fault;
  logic ctl_any_fault;

  // The active-low supply flag is trusted only once the synchroniser has filled
  assign supply_valid = (state_r.settle == SYNC_SETTLE);

  // Supply reset is a fault while its active-low level is low; gated so the
  // all-zero reset state of the synchroniser does not raise the summary at once
  assign supply_reset_seen = supply_valid & ~state_r.pwr_sync.supply_reset_n_flag;

  // Power-stage fault vector, every flag in its fault sense
  always_comb begin
    pwr_fault_vec = 16'h0000;
    pwr_fault_vec[15] = state_r.pwr_sync.regulator_fault_flag; // Regulator fault
    pwr_fault_vec[14] = state_r.pwr_sync.overcurrent_any_flag; // Any overcurrent
    pwr_fault_vec[13] = supply_reset_seen; // Supply reset, inverted sense
    pwr_fault_vec[12] = state_r.pwr_sync.supply_overvoltage_flag; // Supply overvoltage
    pwr_fault_vec[11] = state_r.pwr_sync.thermal_warning_flag; // Thermal warning
    pwr_fault_vec[10] = state_r.pwr_sync.thermal_shutdown_flag; // Thermal shutdown
    pwr_fault_vec[9] = state_r.pwr_sync.phase_c_high_overcurrent; // Phase C high side
    pwr_fault_vec[8] = state_r.pwr_sync.phase_c_low_overcurrent; // Phase C low side
    pwr_fault_vec[7] = state_r.pwr_sync.phase_b_high_overcurrent; // Phase B high side
    pwr_fault_vec[6] = state_r.pwr_sync.phase_b_low_overcurrent; // Phase B low side
    pwr_fault_vec[5] = state_r.pwr_sync.phase_a_high_overcurrent; // Phase A high side
    pwr_fault_vec[4] = state_r.pwr_sync.phase_a_low_overcurrent; // Phase A low side
    pwr_fault_vec[3] = state_r.pwr_sync.otp_error_flag; // Programmable memory error
    pwr_fault_vec[2] = state_r.pwr_sync.regulator_overcurrent_flag; // Regulator overcurrent
    pwr_fault_vec[1] = state_r.pwr_sync.regulator_undervoltage_flag; // Regulator undervoltage
    pwr_fault_vec[0] = state_r.pwr_sync.charge_pump_low_flag; // Charge pump undervoltage
  end

  // Controller fault vector, bit 15 lands on word bit 29 and bit 0 on bit 14
  always_comb begin
    ctl_fault_vec = 16'h0000;
    ctl_fault_vec[15] = state_r.ctl_sync.pulse_freq_fault; // Word bit 29
    ctl_fault_vec[14] = state_r.ctl_sync.pulse_t1_fault; // Word bit 28
    ctl_fault_vec[13] = state_r.ctl_sync.pulse_t2_fault; // Word bit 27
    ctl_fault_vec[12] = state_r.ctl_sync.bus_limit_flag; // Word bit 26
    ctl_fault_vec[11] = state_r.ctl_sync.rl_measure_error; // Word bit 25
    ctl_fault_vec[10] = state_r.ctl_sync.emf_measure_error; // Word bit 24
    ctl_fault_vec[9] = state_r.ctl_sync.speed_abnormal_flag; // Word bit 23
    ctl_fault_vec[8] = state_r.ctl_sync.emf_abnormal_flag; // Word bit 22
    ctl_fault_vec[7] = state_r.ctl_sync.motor_absent_flag; // Word bit 21
    ctl_fault_vec[6] = state_r.ctl_sync.rotor_lock_flag; // Word bit 20
    ctl_fault_vec[5] = state_r.ctl_sync.lock_limit_flag; // Word bit 19
    ctl_fault_vec[4] = state_r.ctl_sync.hw_lock_limit_flag; // Word bit 18
    ctl_fault_vec[3] = state_r.ctl_sync.load_supply_low_flag; // Word bit 17
    ctl_fault_vec[2] = state_r.ctl_sync.load_supply_high_flag; // Word bit 16
    ctl_fault_vec[1] = state_r.ctl_sync.speed_loop_sat_flag; // Word bit 15
    ctl_fault_vec[0] = state_r.ctl_sync.current_loop_sat_flag; // Word bit 14
  end

  // Summaries straight from the live vectors, no extra register stage
  assign pwr_any_fault = |pwr_fault_vec;
  assign ctl_any_fault = |ctl_fault_vec;

  // Power-stage word, rebuilt each cycle from the synchronised flags
  always_comb begin
    pwr_word = PWR_RESET; // Reserved bits stay zero
    pwr_word[PWR_REG_FAULT_BIT] = state_r.pwr_sync.regulator_fault_flag;
    pwr_word[PWR_OC_ANY_BIT] = state_r.pwr_sync.overcurrent_any_flag;
    pwr_word[PWR_POR_N_BIT] = state_r.pwr_sync.supply_reset_n_flag; // Low means reset seen
    pwr_word[PWR_OV_BIT] = state_r.pwr_sync.supply_overvoltage_flag;
    pwr_word[PWR_THERM_ANY_BIT] = state_r.pwr_sync.thermal_warning_flag
      | state_r.pwr_sync.thermal_shutdown_flag;
    pwr_word[PWR_THERM_WARN_BIT] = state_r.pwr_sync.thermal_warning_flag;
    pwr_word[PWR_THERM_SHUT_BIT] = state_r.pwr_sync.thermal_shutdown_flag;
    pwr_word[PWR_SWITCH_LSB+5:PWR_SWITCH_LSB] = {
      state_r.pwr_sync.phase_c_high_overcurrent,
      state_r.pwr_sync.phase_c_low_overcurrent,
      state_r.pwr_sync.phase_b_high_overcurrent,
      state_r.pwr_sync.phase_b_low_overcurrent,
      state_r.pwr_sync.phase_a_high_overcurrent,
      state_r.pwr_sync.phase_a_low_overcurrent};
    pwr_word[PWR_OTP_BIT] = state_r.pwr_sync.otp_error_flag;
    pwr_word[PWR_REG_OC_BIT] = state_r.pwr_sync.regulator_overcurrent_flag;
    pwr_word[PWR_REG_UV_BIT] = state_r.pwr_sync.regulator_undervoltage_flag;
    pwr_word[PWR_CP_UV_BIT] = state_r.pwr_sync.charge_pump_low_flag;
    // Summary; the supply flag counts in its fault sense
    pwr_word[PWR_SUM_BIT] = pwr_any_fault;
  end

  // Controller word: fields 29..14 map straight from the flag struct
  always_comb begin
    ctl_word = CTL_RESET; // Reserved bits stay zero
    ctl_word[CTL_FLAG_MSB:CTL_FLAG_LSB] = ctl_fault_vec;
    ctl_word[CTL_SUM_BIT] = ctl_any_fault; // Same-cycle summary
  end

  // Setup phase is where the registered answer is prepared
  assign setup_phase = i_apb.psel & ~i_apb.penable;

  // Request kind and address hits, acted on in the setup phase only
  assign read_setup = setup_phase & ~i_apb.pwrite;
  assign write_setup = setup_phase & i_apb.pwrite;
  assign pwr_hit = (i_apb.paddr == PWR_ADDR);
  assign ctl_hit = (i_apb.paddr == CTL_ADDR);
  assign addr_known = pwr_hit | ctl_hit;

  // Writes are always refused, reads only where nothing is mapped
  assign refuse = write_setup | (read_setup & ~addr_known);

  // Read data mux; refused or idle accesses return zero
  always_comb begin
    read_word = 32'h0000_0000;
    if (read_setup) begin
      case (i_apb.paddr)
        PWR_ADDR: read_word = pwr_word;
        CTL_ADDR: read_word = ctl_word;
        default: read_word = 32'h0000_0000;
      endcase
    end
  end

  // Next state: two-stage synchronisers, settle counter, read data
  always_comb begin
    state_nxt = state_r;
    state_nxt.pwr_meta = i_pwr_flags;
    state_nxt.pwr_sync = state_r.pwr_meta;
    state_nxt.ctl_meta = i_ctl_flags;
    state_nxt.ctl_sync = state_r.ctl_meta;
    if (!supply_valid) begin
      state_nxt.settle = state_r.settle + 2'h1;
    end
    if (setup_phase) begin
      state_nxt.rdata = read_word;
      state_nxt.slverr = refuse; // Writes refused, contents untouched
    end
  end

  // State register; reset clears both words
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Zero-wait answer; data and error come from flip-flops
  assign o_apb.pready = 1'b1;
  assign o_apb.pslverr = state_r.slverr;
  assign o_apb.prdata = state_r.rdata;
  assign o_pwr_fault = pwr_word[PWR_SUM_BIT];
  assign o_ctl_fault = ctl_word[CTL_SUM_BIT];

endmodule : fsrb_top

// file: dv/fsrb_checker.sv
// Checker for the fault status bank: summaries, word layout, refusals.
// Assumes the single clock and the ports of fsrb_top.
`timescale 1ns/100ps
module fsrb_checker (
  // Clock, reset and bus
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire fsrb_pkg::fsrb_apb_req_s i_apb,
  input wire fsrb_pkg::fsrb_apb_rsp_s o_apb,
  // Flags and summaries
  input wire fsrb_pkg::fsrb_pwr_flags_s i_pwr_flags,
  input wire fsrb_pkg::fsrb_ctl_flags_s i_ctl_flags,
  input wire logic o_pwr_fault,
  input wire logic o_ctl_fault
);
  import fsrb_pkg::*;
  logic [2:0] cnt_r;
  logic acc;
  logic rd_p;
  logic rd_c;
  logic [31:0] d;
  // Access phases once the synchronisers have settled
  assign acc = i_apb.psel && i_apb.penable && cnt_r == 3'h4;
  assign rd_p = acc && !i_apb.pwrite && i_apb.paddr == PWR_ADDR;
  assign rd_c = acc && !i_apb.pwrite && i_apb.paddr == CTL_ADDR;
  assign d = o_apb.prdata;
  // Cycles since reset release, saturating at four
  always_ff @(posedge i_clk) begin
    if (!i_rstn) cnt_r <= 3'h0;
    else if (cnt_r != 3'h4) cnt_r <= cnt_r + 3'h1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  property p_rst; $rose(i_rstn) |-> d == 32'h0 && !o_pwr_fault && !o_ctl_fault; endproperty
  a_rst: assert property (p_rst) else $error("state not zero after reset");
  property p_pwr_sum; cnt_r == 3'h4 |-> o_pwr_fault == |($past(i_pwr_flags, 2) ^ 16'h2000); endproperty
  a_pwr_sum: assert property (p_pwr_sum) else $error("power summary wrong");
  property p_ctl_sum; cnt_r == 3'h4 |-> o_ctl_fault == |$past(i_ctl_flags, 2); endproperty
  a_ctl_sum: assert property (p_ctl_sum) else $error("controller summary wrong");
  property p_pwr_rd; rd_p |-> d[31] == |(d[30:0] ^ 31'h0800_0000); endproperty
  a_pwr_rd: assert property (p_pwr_rd) else $error("power word bit 31 wrong");
  property p_therm; rd_p |-> d[25] == (d[23] | d[22]); endproperty
  a_therm: assert property (p_therm) else $error("thermal bit wrong");
  property p_pwr_rsv; rd_p |-> {d[29], d[24], d[15], d[10:0]} == 14'h0; endproperty
  a_pwr_rsv: assert property (p_pwr_rsv) else $error("power reserved bit set");
  property p_ctl_rd; rd_c |-> d[31] == |d[29:14] && !d[30] && d[13:0] == 14'h0; endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("controller word wrong");
  property p_wr; acc && i_apb.pwrite |-> o_apb.pslverr && d == 32'h0; endproperty
  a_wr: assert property (p_wr) else $error("write not refused");
  // Main scenarios
  c_pwr: cover property (o_pwr_fault);
  c_ctl: cover property (o_ctl_fault);
  c_wr: cover property (acc && i_apb.pwrite);
endmodule : fsrb_checker
bind fsrb_top fsrb_checker i_chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_apb(i_apb), .o_apb(o_apb),
  .i_pwr_flags(i_pwr_flags), .i_ctl_flags(i_ctl_flags), .o_pwr_fault(o_pwr_fault), .o_ctl_fault(o_ctl_fault));

// file: dv/tb_fault_status_register_bank.sv
// Testbench of the fault status bank: reset, flag walks, refusals.
// Assumes fsrb_top with its bound checker; the bench is the APB master.
`timescale 1ns/100ps
module tb_fault_status_register_bank;
  import fsrb_pkg::*;
  logic i_clk;
  logic i_rstn;
  fsrb_apb_req_s req;
  fsrb_apb_rsp_s rsp;
  fsrb_pwr_flags_s pf;
  fsrb_ctl_flags_s cf;
  logic pw_f;
  logic ct_f;
  int num_errors;
  int num_checks;
  fsrb_top i_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_apb(req), .o_apb(rsp), .i_pwr_flags(pf),
    .i_ctl_flags(cf), .o_pwr_fault(pw_f), .o_ctl_fault(ct_f));
  // 250 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  task automatic results;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", s, e, g);
      num_errors++;
    end
  endtask : chk
  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [APB_AW-1:0] a, output logic [31:0] d, output logic e);
    int n;
    n = 0;
    @(posedge i_clk);
    req <= '{1'b1, 1'b0, w, a, 32'hffff_ffff};
    @(posedge i_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    chk("pready", 32'h1, {31'h0, rsp.pready});
    d = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [APB_AW-1:0] a, input logic [31:0] x);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, d, e);
    chk("prdata", x, d);
    chk("pslverr", 32'h0, {31'h0, e});
  endtask : rd
  // Expected power word from detector levels
  function automatic logic [31:0] exp_pwr(input logic [15:0] f);
    logic [31:0] w;
    w = {1'b0, f[15], 1'b0, f[14:12], f[11] | f[10], 1'b0, f[11:4], 1'b0, f[3:0], 11'h0};
    w[31] = |(f ^ 16'h2000);
    return w;
  endfunction : exp_pwr
  task automatic t_pwr;
    logic [15:0] f;
    for (int i = 0; i <= 16; i++) begin
      f = 16'h2000 ^ (i < 16 ? 16'h1 << i : 16'h0);
      @(posedge i_clk);
      pf <= f;
      repeat (3) @(posedge i_clk);
      rd(PWR_ADDR, exp_pwr(f));
      chk("o_pwr_fault", exp_pwr(f) >> 31, {31'h0, pw_f});
    end
    $display("test power walk done");
  endtask : t_pwr
  task automatic t_ctl;
    logic [15:0] f;
    for (int i = 0; i <= 16; i++) begin
      f = i < 16 ? 16'h1 << i : 16'h0;
      @(posedge i_clk);
      cf <= f;
      repeat (3) @(posedge i_clk);
      rd(CTL_ADDR, {|f, 1'b0, f, 14'h0});
      chk("o_ctl_fault", {31'h0, |f}, {31'h0, ct_f});
    end
    $display("test controller walk done");
  endtask : t_ctl
  // Mid-run reset with every flag raised: summaries and power word clear at once, controller word refills
  task automatic t_reset;
    @(posedge i_clk);
    pf <= '1;
    cf <= '1;
    repeat (4) @(posedge i_clk);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    chk("o_pwr_fault", 32'h0, {31'h0, pw_f});
    chk("o_ctl_fault", 32'h0, {31'h0, ct_f});
    rd(PWR_ADDR, PWR_RESET);
    rd(CTL_ADDR, {2'h2, 16'hffff, 14'h0});
    rd(PWR_ADDR, exp_pwr(16'hffff));
    $display("test mid-run reset done");
  endtask : t_reset
  // Writes and unmapped reads are refused
  task automatic t_refuse;
    logic [APB_AW-1:0] ad [3] = '{PWR_ADDR, CTL_ADDR, 12'h384};
    logic [31:0] d;
    logic e;
    for (int k = 0; k < 3; k++) begin
      apb(k < 2, ad[k], d, e);
      chk("refused data", 32'h0, d);
      chk("refused err", 32'h1, {31'h0, e});
    end
    rd(PWR_ADDR, exp_pwr(pf));
    $display("test refusals done");
  endtask : t_refuse
  // Main sequence
  initial begin
    num_errors = 0;
    num_checks = 0;
    i_rstn = 1'b0;
    req = '0;
    pf = '0;
    cf = '0;
    repeat (4) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(PWR_ADDR, PWR_RESET);
    rd(CTL_ADDR, CTL_RESET);
    $display("test reset done");
    t_pwr();
    t_ctl();
    t_reset();
    t_refuse();
    results();
  end
endmodule : tb_fault_status_register_bank
